// File: hw/pgc_regs.vh
// Register offsets, fields, reset values and default bus width for the panel geometry block
`ifndef PGC_REGS_VH
`define PGC_REGS_VH
`define PGC_OFS_PANEL_TYPE 8'h14
`define PGC_OFS_ACTIVE_WIDTH 8'h16
`define PGC_OFS_HBLANK 8'h18
`define PGC_OFS_HEIGHT_LOW 8'h1A
`define PGC_OFS_HEIGHT_HIGH 8'h1C
`define PGC_OFS_VBLANK 8'h1E
`define PGC_OFS_STATUS 8'h30
`define PGC_RST_PANEL_TYPE 8'h00
`define PGC_RST_ACTIVE_WIDTH 8'h01
`define PGC_RST_HBLANK 8'h00
`define PGC_RST_HEIGHT_LOW 8'h01
`define PGC_RST_HEIGHT_HIGH 8'h00
`define PGC_RST_VBLANK 8'h01
`define PGC_BIT_SWAP 7
`define PGC_BIT_RESERVED 0
`define PGC_WIDTH_SHIFT 3
`define PGC_DEF_DATA_BITS 18
`endif

// File: hw/pgc_bus_swap.v
// Panel data bus bit-order swap over the active pins only
`timescale 1ns/1ps
module pgc_bus_swap #(
  parameter DATA_BITS = 18
) (
  input wire [DATA_BITS-1:0] pixel_in, // Pixel data in native order
  input wire swap_in, // Reverse bit order when high
  input wire [4:0] active_bits_in, // Number of active pins, 1..DATA_BITS
  output reg [DATA_BITS-1:0] pin_out // Data towards the panel pins
);
  integer i;

  // Mirror inside the active field only; unused upper pins stay zero
  always @* begin
    pin_out = {DATA_BITS{1'b0}};
    for (i = 0; i < DATA_BITS; i = i + 1) begin
      if (i < active_bits_in) begin
        if (swap_in)
          pin_out[i] = pixel_in[active_bits_in - 1 - i];
        else
          pin_out[i] = pixel_in[i];
      end
    end
  end
endmodule // pgc_bus_swap

// File: hw/pgc_panel_geometry.v
// Panel geometry registers, Wishbone slave and line/frame timing generator
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "pgc_regs.vh"

// Behaviour
// - Swap bit 7 of panel type reverses panel data bus bit order.
// - Reversal spans only the pins active for the configured panel width.
// - Active line width in pixels is the 7-bit width field times 8.
// - Horizontal blank period in pixels is taken directly from its 7-bit field.
// - Active height is 10 bits: high register bits 1-0 over low register.
// - Active height counts lines at one-line resolution, minimum one line.
module pgc_panel_geometry #(
  parameter DATA_BITS = `PGC_DEF_DATA_BITS
) (
  input wire core_clk_in, // System clock, 40 MHz
  input wire rst_n_in, // Asynchronous reset, active low
  input wire wb_cyc_in, // Wishbone cycle
  input wire wb_stb_in, // Wishbone strobe
  input wire wb_we_in, // Wishbone write enable
  input wire [7:0] wb_adr_in, // Wishbone byte address
  input wire [3:0] wb_sel_in, // Wishbone byte selects
  input wire [31:0] wb_dat_in, // Wishbone write data
  output reg [31:0] wb_dat_out, // Wishbone read data
  output reg wb_ack_out, // Wishbone acknowledge
  output reg wb_err_out, // Wishbone error, unmapped address
  input wire [DATA_BITS-1:0] pixel_in, // Pixel data from the frame source
  input wire [4:0] active_bits_in, // Active panel data pins, 1..DATA_BITS
  output reg [DATA_BITS-1:0] panel_data_bus_out, // Data to the panel pins
  output reg display_enable_out, // High during active pixels
  output reg line_start_out, // Pulse at pixel 0 of each line
  output reg frame_start_out, // Pulse at pixel 0 of line 0
  output reg pixel_req_out // Request next pixel, one cycle ahead
);
  // Phase codes shared by the line and frame sequencers
  localparam ST_ACTIVE = 1'b0;
  localparam ST_BLANK = 1'b1;
  // Widest pin count that the swap network can mirror
  localparam [4:0] MAX_PINS = DATA_BITS;

  // Software-visible register file
  reg [7:0] panel_type_reg;
  reg [7:0] active_width_reg;
  reg [7:0] hblank_reg;
  reg [7:0] height_low_reg;
  reg [7:0] height_high_reg;
  reg [7:0] vblank_reg;

  // Pixel and line counters with their phase flags
  reg [9:0] hcount_reg;
  reg [9:0] hcount_next;
  reg [9:0] vcount_reg;
  reg [9:0] vcount_next;
  reg hstate_reg;
  reg hstate_next;
  reg vstate_reg;
  reg vstate_next;

  // Geometry in pixels and lines, bus decode and swap network wiring
  wire [9:0] line_pixels;
  wire [9:0] blank_pixels;
  wire [9:0] frame_lines;
  wire [9:0] vblank_lines;
  wire [DATA_BITS-1:0] swapped;
  wire [4:0] pins_used;
  wire req;
  wire hit;
  wire wr_en;
  wire rd_en;
  wire line_end;
  reg [31:0] rd_data;

  // Byte lane 0 carries the 8-bit registers
  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input sel0;
    begin
      merge_byte = sel0 ? new_val : old_val;
    end
  endfunction

  // Zero counts would stall the counters, so clamp to one
  function [9:0] at_least_one;
    input [9:0] val;
    begin
      at_least_one = (val == 10'h000) ? 10'h001 : val;
    end
  endfunction

  // Both sequencers in their active phase; used by enable, data and request
  function both_active;
    input h_state;
    input v_state;
    begin
      both_active = (h_state == ST_ACTIVE) && (v_state == ST_ACTIVE);
    end
  endfunction

  // A pin count of zero or above the bus width would index missing pins,
  // so it is pulled back into range before the mirror sees it
  function [4:0] clamp_pins;
    input [4:0] val;
    begin
      if (val == 5'h00)
        clamp_pins = 5'h01;
      else if (val > MAX_PINS)
        clamp_pins = MAX_PINS;
      else
        clamp_pins = val;
    end
  endfunction

  // A request is taken only while no answer shows, so one strobe gets one answer
  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
  assign wr_en = req & hit & wb_we_in;
  assign rd_en = req & hit & ~wb_we_in;

  // Geometry in pixels and lines; zero width and height are clamped so the counters always wrap
  assign line_pixels = at_least_one({active_width_reg[6:0], 3'h0});
  assign blank_pixels = {3'h0, hblank_reg[6:0]};
  assign frame_lines = at_least_one({height_high_reg[1:0], height_low_reg});
  assign vblank_lines = {2'h0, vblank_reg};
  assign pins_used = clamp_pins(active_bits_in);

  // Address decode over the six geometry registers and the status word;
  // any other address answers with err and changes nothing
  assign hit = (wb_adr_in == `PGC_OFS_PANEL_TYPE) || (wb_adr_in == `PGC_OFS_ACTIVE_WIDTH) ||
               (wb_adr_in == `PGC_OFS_HBLANK) || (wb_adr_in == `PGC_OFS_HEIGHT_LOW) ||
               (wb_adr_in == `PGC_OFS_HEIGHT_HIGH) || (wb_adr_in == `PGC_OFS_VBLANK) ||
               (wb_adr_in == `PGC_OFS_STATUS);

  // Read mux; unused bits read as zero
  always @* begin
    rd_data = 32'h00000000;
    case (wb_adr_in)
      `PGC_OFS_PANEL_TYPE: rd_data[7:0] = panel_type_reg;
      `PGC_OFS_ACTIVE_WIDTH: rd_data[7:0] = active_width_reg;
      `PGC_OFS_HBLANK: rd_data[7:0] = hblank_reg;
      `PGC_OFS_HEIGHT_LOW: rd_data[7:0] = height_low_reg;
      `PGC_OFS_HEIGHT_HIGH: rd_data[7:0] = height_high_reg;
      `PGC_OFS_VBLANK: rd_data[7:0] = vblank_reg;
      // Status is read-only: phases and counters, for software to poll the position
      `PGC_OFS_STATUS: rd_data = {10'h000, vstate_reg, hstate_reg, vcount_reg, hcount_reg};
      default: rd_data = 32'h00000000;
    endcase
  end

  // Bus slave: one wait-free answer, ack one cycle after the request
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_err_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
      // Registers come up at their power-on defaults
      panel_type_reg <= `PGC_RST_PANEL_TYPE;
      active_width_reg <= `PGC_RST_ACTIVE_WIDTH;
      hblank_reg <= `PGC_RST_HBLANK;
      height_low_reg <= `PGC_RST_HEIGHT_LOW;
      height_high_reg <= `PGC_RST_HEIGHT_HIGH;
      vblank_reg <= `PGC_RST_VBLANK;
    end else begin
      wb_ack_out <= req & hit;
      wb_err_out <= req & ~hit;
      // Read data is captured with the ack and then held until the next read
      if (rd_en)
        wb_dat_out <= rd_data;
      // Only byte lane 0 carries register bits; sel[3:1] select nothing here,
      // and a clear sel[0] leaves the register as it was
      if (wr_en) begin
        case (wb_adr_in)
          // Reserved bit 0 is stored as written; software leaves it alone
          `PGC_OFS_PANEL_TYPE: panel_type_reg <= merge_byte(panel_type_reg, wb_dat_in[7:0],
                                                           wb_sel_in[0]);
          // Minimum of one is the caller's duty; the counter clamps a zero
          `PGC_OFS_ACTIVE_WIDTH: active_width_reg <= merge_byte(active_width_reg,
                                                               wb_dat_in[7:0], wb_sel_in[0]);
          // Values below three or short of the sync span are not trapped
          `PGC_OFS_HBLANK: hblank_reg <= merge_byte(hblank_reg, wb_dat_in[7:0], wb_sel_in[0]);
          `PGC_OFS_HEIGHT_LOW: height_low_reg <= merge_byte(height_low_reg, wb_dat_in[7:0],
                                                           wb_sel_in[0]);
          `PGC_OFS_HEIGHT_HIGH: height_high_reg <= merge_byte(height_high_reg,
                                                             wb_dat_in[7:0], wb_sel_in[0]);
          `PGC_OFS_VBLANK: vblank_reg <= merge_byte(vblank_reg, wb_dat_in[7:0], wb_sel_in[0]);
          default: ;
        endcase
      end
    end
  end

  // Last pixel of a line: end of blank, or end of active when there is no blank.
  // The vertical counter steps here, so a width change mid-line only moves this edge.
  assign line_end = (hstate_reg == ST_BLANK) ? (hcount_reg + 10'h001 >= blank_pixels)
                                             : (hcount_reg + 10'h001 >= line_pixels) &&
                                               (blank_pixels == 10'h000);

  // Horizontal and vertical sequencers; settings take effect on the fly
  always @* begin
    // Defaults: count on and stay in phase
    hcount_next = hcount_reg + 10'h001;
    hstate_next = hstate_reg;
    vcount_next = vcount_reg;
    vstate_next = vstate_reg;
    case (hstate_reg)
      ST_ACTIVE: begin
        // Width reached: blank if there is one, else straight into the next line
        if (hcount_reg + 10'h001 >= line_pixels) begin
          hcount_next = 10'h000;
          if (blank_pixels != 10'h000)
            hstate_next = ST_BLANK;
        end
      end
      ST_BLANK: begin
        // Blank count reached: the next line starts active
        if (hcount_reg + 10'h001 >= blank_pixels) begin
          hcount_next = 10'h000;
          hstate_next = ST_ACTIVE;
        end
      end
      default: begin
        hcount_next = 10'h000;
        hstate_next = ST_ACTIVE;
      end
    endcase
    // Lines advance only at the end of a whole line, blank pixels included
    if (line_end) begin
      vcount_next = vcount_reg + 10'h001;
      case (vstate_reg)
        ST_ACTIVE: begin
          // Last active line: vertical blank follows unless it is set to zero
          if (vcount_reg + 10'h001 >= frame_lines) begin
            vcount_next = 10'h000;
            if (vblank_lines != 10'h000)
              vstate_next = ST_BLANK;
          end
        end
        ST_BLANK: begin
          // Vertical blank done: the next frame begins
          if (vcount_reg + 10'h001 >= vblank_lines) begin
            vcount_next = 10'h000;
            vstate_next = ST_ACTIVE;
          end
        end
        default: begin
          vcount_next = 10'h000;
          vstate_next = ST_ACTIVE;
        end
      endcase
    end
  end

  // Counter and phase registers; reset starts at pixel 0 of the first active line
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hcount_reg <= 10'h000;
      vcount_reg <= 10'h000;
      hstate_reg <= ST_ACTIVE;
      vstate_reg <= ST_ACTIVE;
    end else begin
      hcount_reg <= hcount_next;
      vcount_reg <= vcount_next;
      hstate_reg <= hstate_next;
      vstate_reg <= vstate_next;
    end
  end

  // Mirror network between the pixel source and the output flops
  pgc_bus_swap #(
    .DATA_BITS(DATA_BITS)
  ) i_pgc_bus_swap (
    .pixel_in(pixel_in),
    .swap_in(panel_type_reg[`PGC_BIT_SWAP]),
    .active_bits_in(pins_used),
    .pin_out(swapped)
  );

  // Panel outputs registered; enable, data and markers one cycle behind the counters, the request in line with them
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Everything towards the panel is quiet in reset
      panel_data_bus_out <= {DATA_BITS{1'b0}};
      display_enable_out <= 1'b0;
      line_start_out <= 1'b0;
      frame_start_out <= 1'b0;
      pixel_req_out <= 1'b0;
    end else begin
      // Enable and data follow the current phase, one cycle behind the counters
      display_enable_out <= both_active(hstate_reg, vstate_reg);
      panel_data_bus_out <= both_active(hstate_reg, vstate_reg) ?
                            swapped : {DATA_BITS{1'b0}};
      // Line marker flags pixel 0 of every line, vertical blank too; frame marker the first active pixel
      line_start_out <= (hcount_reg == 10'h000) && (hstate_reg == ST_ACTIVE);
      frame_start_out <= (hcount_reg == 10'h000) && (hstate_reg == ST_ACTIVE) &&
                         (vcount_reg == 10'h000) && (vstate_reg == ST_ACTIVE);
      // The request looks at the next phase so the source has a cycle to fetch;
      // it rests low in reset, so the first pixel after reset comes unrequested
      pixel_req_out <= both_active(hstate_next, vstate_next);
    end
  end
endmodule // pgc_panel_geometry

// File: testbench/pgc_panel_properties.sv
// Checker for bus handshake and panel timing
`timescale 1ns/1ps
module pgc_panel_properties #(
  parameter DATA_BITS = 18
) (
  input wire core_clk_in, // Clock
  input wire rst_n_in, // Reset
  input wire wb_cyc_in, // Cycle
  input wire wb_stb_in, // Strobe
  input wire [7:0] wb_adr_in, // Address
  input wire [31:0] wb_dat_out, // Read data
  input wire wb_ack_out, // Ack
  input wire wb_err_out, // Error
  input wire display_enable_out, // Active
  input wire line_start_out, // Line
  input wire frame_start_out, // Frame
  input wire pixel_req_out // Request
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // New request only outside the answer cycle; map is even 14h..1Eh plus status
  wire req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  wire hit = (wb_adr_in >= 8'h14 && wb_adr_in <= 8'h1E && !wb_adr_in[0]) || wb_adr_in == 8'h30;
  property p_ack; req && hit |=> wb_ack_out && !wb_err_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_err; req && !hit |=> wb_err_out && !wb_ack_out; endproperty
  a_err: assert property (p_err) else $error("no err");
  property p_one; wb_ack_out |=> !wb_ack_out; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_eone; wb_err_out |=> !wb_err_out; endproperty
  a_eone: assert property (p_eone) else $error("long err");
  property p_hold; !wb_ack_out |-> $stable(wb_dat_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_frame; frame_start_out |-> line_start_out && display_enable_out; endproperty
  a_frame: assert property (p_frame) else $error("frame start");
  property p_line; line_start_out |=> !line_start_out [*7]; endproperty
  a_line: assert property (p_line) else $error("short line");
  property p_run; $rose(display_enable_out) |-> display_enable_out [*8]; endproperty
  a_run: assert property (p_run) else $error("short run");
  property p_req; pixel_req_out |=> display_enable_out; endproperty
  a_req: assert property (p_req) else $error("request without pixel");
  property p_req_end; $fell(pixel_req_out) |=> !display_enable_out; endproperty
  a_req_end: assert property (p_req_end) else $error("pixel after request end");
endmodule // pgc_panel_properties
bind pgc_panel_geometry pgc_panel_properties #(.DATA_BITS(DATA_BITS)) i_pgc_panel_properties (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .wb_err_out(wb_err_out), .display_enable_out(display_enable_out),
  .line_start_out(line_start_out), .frame_start_out(frame_start_out),
  .pixel_req_out(pixel_req_out));

// File: testbench/pgc_panel_model.sv
// Panel model measuring active run, line period, frame lines and pixel data
`timescale 1ns/1ps
module pgc_panel_model #(
  parameter DATA_BITS = 18
) (
  input wire core_clk_in, // Clock
  input wire [DATA_BITS-1:0] panel_data_bus_in, // Pins
  input wire display_enable_in, // Active
  input wire frame_start_in, // Frame
  output logic [15:0] width_out, // Last run
  output logic [15:0] period_out, // Last period
  output logic [15:0] lines_out, // Frame lines
  output logic [DATA_BITS-1:0] data_out // Last pixel
);
  logic [15:0] run_reg = 16'h0, per_reg = 16'h0, cnt_reg = 16'h0;
  wire line_go = display_enable_in && run_reg == 16'h0;
  // Pixels taken only while enabled; a period across vertical blank is skipped
  always @(posedge core_clk_in) begin
    run_reg <= display_enable_in ? run_reg + 16'h1 : 16'h0;
    per_reg <= line_go ? 16'h1 : per_reg + 16'h1;
    if (display_enable_in) data_out <= panel_data_bus_in;
    if (!display_enable_in && run_reg != 16'h0) width_out <= run_reg;
    if (line_go && !frame_start_in) period_out <= per_reg;
    if (line_go) cnt_reg <= frame_start_in ? 16'h1 : cnt_reg + 16'h1;
    if (frame_start_in) lines_out <= cnt_reg;
  end
endmodule // pgc_panel_model

// File: testbench/pgc_panel_geometry_test.sv
// Self-checking bench for the panel geometry block
`timescale 1ns/1ps
module pgc_panel_geometry_test;
  typedef struct packed {logic [7:0] w, hb, hl, hh, pt; logic [4:0] nb;
    logic [17:0] px, ed;} pgc_row_t;
  // Width, blank, height low/high, type, pins, pixel, then the expected pin data
  pgc_row_t rows [3] = '{'{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 5'h12, 18'h2AAAA, 18'h2AAAA},
    '{8'h02, 8'h04, 8'h03, 8'h00, 8'h80, 5'h12, 18'h00001, 18'h20000},
    '{8'h03, 8'h05, 8'h01, 8'h01, 8'h80, 5'h08, 18'h3FF03, 18'h000C0}};
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, rerr;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd;
  logic [17:0] pix = 18'h0;
  logic [4:0] bits = 5'h12;
  logic [3:0] sel = 4'hF, wsel = 4'hF;
  wire [31:0] rdat;
  wire ack, err, de, fs;
  wire [17:0] bus, m_data;
  wire [15:0] m_width, m_period, m_lines;
  int miscompares = 0, n_tests = 0, cycles = 0;
  pgc_panel_geometry i_pgc_panel_geometry (.core_clk_in(clk), .rst_n_in(rst_n),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err), .pixel_in(pix),
    .active_bits_in(bits), .panel_data_bus_out(bus), .display_enable_out(de),
    .line_start_out(), .frame_start_out(fs), .pixel_req_out());
  pgc_panel_model i_pgc_panel_model (.core_clk_in(clk), .panel_data_bus_in(bus),
    .display_enable_in(de), .frame_start_in(fs), .width_out(m_width),
    .period_out(m_period), .lines_out(m_lines), .data_out(m_data));
  initial forever #12.5 clk = ~clk;
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_of_test;
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Request held until ack or err is sampled, then one idle cycle
  task bus_cycle(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, 24'h0, d, wsel};
    @(posedge clk);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
    rd = rdat;
    rerr = err;
    {cyc, stb} <= 2'b00;
  endtask
  // Two frame starts leave one clean frame in the model
  task frames;
    repeat (2) begin
      @(posedge clk);
      while (fs !== 1'b1) @(posedge clk);
    end
    @(posedge clk);
  endtask
  // Hang guard, well above the longest frame pair
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus_cycle(1'b1, 8'h16, rows[i].w);
      bus_cycle(1'b1, 8'h18, rows[i].hb);
      bus_cycle(1'b1, 8'h1A, rows[i].hl);
      bus_cycle(1'b1, 8'h1C, rows[i].hh);
      bus_cycle(1'b1, 8'h14, rows[i].pt);
      pix <= rows[i].px;
      bits <= rows[i].nb;
      frames;
      check("width", {rows[i].w[6:0], 3'b000}, m_width);
      check("period", {rows[i].w[6:0], 3'b000} + rows[i].hb[6:0], m_period);
      check("lines", {rows[i].hh[1:0], rows[i].hl}, m_lines);
      check("data", rows[i].ed, m_data);
    end
    // Second reset mid-frame, defaults, unmapped read and the minimum frame
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus_cycle(1'b0, 8'h14 + 8'(2 * i), 8'h00);
      check("reset", {31'h0, i[0]}, rd);
    end
    bus_cycle(1'b0, 8'h02, 8'h00);
    check("unmapped", 32'h1, rerr);
    check("unmapped data", 32'h1, rd);
    // A write with lane 0 off must leave the width register alone
    wsel = 4'h0;
    bus_cycle(1'b1, 8'h16, 8'h05);
    wsel = 4'hF;
    bus_cycle(1'b0, 8'h16, 8'h00);
    check("lane 0 off", 32'h1, rd);
    bus_cycle(1'b0, 8'h30, 8'h00);
    check("status top", 32'h0, {22'h0, rd[31:22]});
    frames;
    check("min width", 32'h8, m_width);
    check("min lines", 32'h1, m_lines);
    end_of_test;
  end
endmodule // pgc_panel_geometry_test
